// ===== seg_port_pkg.sv
// register map, reset values and timing for the segment pin port mux
package seg_port_pkg;
  // ==========================================================
  // register indices, byte address is four times the index
  localparam logic [6:0] IDX_X_GROUP = 7'h0c; // port x group load
  localparam logic [6:0] IDX_SEL     = 7'h11; // segment port select
  localparam logic [6:0] IDX_ADC     = 7'h14; // converter channel
  localparam logic [6:0] IDX_CTRL    = 7'h15; // display and key scan
  localparam logic [6:0] IDX_KEY     = 7'h17; // captured key data
  localparam logic [6:0] IDX_Y_GROUP = 7'h42; // port y group load
  localparam logic [6:0] IDX_X_LO    = 7'h68; // port x low nibble
  localparam logic [6:0] IDX_X_HI    = 7'h69; // port x high nibble
  localparam logic [6:0] IDX_E       = 7'h6b; // port e nibble
  localparam logic [6:0] IDX_F       = 7'h6d; // port f nibble
  localparam logic [6:0] IDX_D_IN    = 7'h72; // port d pin levels
  // ==========================================================
  // field positions
  localparam int SEL_F_BIT     = 0; // 1: group f general output
  localparam int SEL_E_BIT     = 1; // 1: group e general output
  localparam int SEL_X_BIT     = 2; // 1: group x general output
  localparam int SEL_Y_BIT     = 3; // 1: group y general output
  localparam int CTRL_DISP_BIT = 0; // display on
  localparam int CTRL_SCAN_BIT = 1; // key scan on group y
  // ==========================================================
  // values after reset
  localparam logic [3:0]  SEL_RST  = 4'h0;    // all segment outputs
  localparam logic [3:0]  ADC_RST  = 4'h0;    // no port d channel
  localparam logic [1:0]  CTRL_RST = 2'h0;    // display off
  localparam logic [3:0]  NIB_RST  = 4'h0;    // data nibbles
  localparam logic [15:0] Y_RST    = 16'h0000; // port y latch
  localparam logic [3:0]  ADC_CH_D0 = 4'h2;   // channel of pin d0
  localparam logic [1:0]  RESP_OKAY   = 2'h0; // axi okay
  localparam logic [1:0]  RESP_SLVERR = 2'h2; // axi slave error
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS   = 50;     // 20 mhz
  localparam int KEY_SRC_TIME_NS = 220000; // key source period
  localparam int SEG_TIME_NS     = 220000; // segment period
  localparam int KEY_SRC_CYCLES  = (KEY_SRC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEG_CYCLES      = (SEG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==========================================================
  // key scan phase
  typedef enum logic [1:0] {
    PH_SEG = 2'b01, // pins carry segment drive
    PH_KEY = 2'b10  // group y carries key source
  } scan_phase_t;
endpackage : seg_port_pkg

// ===== bit_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module bit_sync #(
  parameter int W = 4 // bits
) (
  input  wire logic         aclk,    // clock
  input  wire logic         aresetn, // sync reset, low
  input  wire logic [W-1:0] d,       // async pins
  output logic      [W-1:0] sync_ff  // synchronised
);
  logic [W-1:0] meta_ff; // first stage, read only by sync_ff
  // ==========================================================
  // two stages
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end
endmodule : bit_sync
`default_nettype wire

// ===== seg_pin_group.sv
// output selection for one group of shared segment pins
`timescale 1ns/1ns
`default_nettype none
module seg_pin_group #(
  parameter int W = 4 // pins in group
) (
  input  wire logic         aclk,      // clock
  input  wire logic         aresetn,   // sync reset, low
  input  wire logic         gp_mode,   // general output role
  input  wire logic         disp_on,   // display on
  input  wire logic         key_phase, // key source slot
  input  wire logic [W-1:0] seg_drv,   // segment drive
  input  wire logic [W-1:0] port_dat,  // port latch
  input  wire logic [W-1:0] key_dat,   // key source pattern
  output logic      [W-1:0] pin_ff     // pin level
);
  logic [W-1:0] nxt_pin; // selected level
  // ==========================================================
  // display off gives steady low on segment pins outside the key slot
  assign nxt_pin = gp_mode   ? port_dat :
                   key_phase ? key_dat :
                   disp_on   ? seg_drv : '0;
  always_ff @(posedge aclk) begin
    if (!aresetn) pin_ff <= '0;
    else          pin_ff <= nxt_pin;
  end
endmodule : seg_pin_group
`default_nettype wire

// ===== segment_pin_port_mux.sv
// shared segment pin port mux with axi4-lite register slave
//
// Notes on behaviour
// - port f data is dot nibble 13
// - port e data is dot nibble 11
// - port x from nibbles 9 and 8
// - port x loadable via group register
// - port y loadable via group register
// - power-on or clock stop: segments, display off
// - display off drives steady low; group y still carries key source in the key slot
// - ce reset keeps every pin role
// - port d is 4-bit input port
// - converter channel picks port d role
// - port d pins have pull-downs
// - reading port d returns pin levels
// - select register picks output or segment
// - scan pull-downs only in key period
// - converter pin alone loses pull-down
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module segment_pin_port_mux #(
  parameter int KEY_CYCLES = seg_port_pkg::KEY_SRC_CYCLES, // key slot
  parameter int SEG_CYCLES = seg_port_pkg::SEG_CYCLES      // seg slot
) (
  input  wire logic        aclk,          // clock, 20 mhz
  input  wire logic        aresetn,       // power-on reset, low
  input  wire logic        clock_stop,    // clock stop pulse
  input  wire logic        ce_reset,      // ce reset pulse
  // axi4-lite slave
  input  wire logic [11:0] s_awaddr,      // write address
  input  wire logic        s_awvalid,     // write address valid
  output logic             s_awready,     // write address ready
  input  wire logic [31:0] s_wdata,       // write data
  input  wire logic [3:0]  s_wstrb,       // byte strobes
  input  wire logic        s_wvalid,      // write data valid
  output logic             s_wready,      // write data ready
  output logic [1:0]       s_bresp,       // write response
  output logic             s_bvalid,      // response valid
  input  wire logic        s_bready,      // response ready
  input  wire logic [11:0] s_araddr,      // read address
  input  wire logic        s_arvalid,     // read address valid
  output logic             s_arready,     // read address ready
  output logic [31:0]      s_rdata,       // read data
  output logic [1:0]       s_rresp,       // read response
  output logic             s_rvalid,      // read valid
  input  wire logic        s_rready,      // read ready
  // lcd controller side
  input  wire logic [3:0]  lcd_seg_f,     // segment drive f
  input  wire logic [3:0]  lcd_seg_e,     // segment drive e
  input  wire logic [5:0]  lcd_seg_x,     // segment drive x
  input  wire logic [15:0] lcd_seg_y,     // segment drive y
  output logic [3:0]       dot_nibble_13, // dot data to lcd
  output logic [3:0]       dot_nibble_11, // dot data to lcd
  output logic [3:0]       dot_nibble_9,  // dot data to lcd
  output logic [3:0]       dot_nibble_8,  // dot data to lcd
  // pins
  output logic [3:0]       seg_pin_f,     // pins of group f
  output logic [3:0]       seg_pin_e,     // pins of group e
  output logic [5:0]       seg_pin_x,     // pins of group x
  output logic [15:0]      seg_pin_y,     // pins of group y
  output logic             key_scan_drive, // key source slot
  input  wire logic [3:0]  port_d_pin,    // port d pins
  output logic [3:0]       port_d_pulldown, // pull-down enables
  output logic [3:0]       port_d_adc_sel // pin to converter
);
  // ==========================================================
  // register state
  logic [3:0]  seg_group_f_out_ff; // port f / dot 13
  logic [3:0]  seg_group_e_out_ff; // port e / dot 11
  logic [3:0]  seg_group_x_hi_ff;  // port x hi / dot 9
  logic [3:0]  seg_group_x_lo_ff;  // port x lo / dot 8
  logic [15:0] port_y_ff;          // port y latch
  logic [3:0]  sel_ff;             // segment port select
  logic [3:0]  adc_ff;             // converter channel
  logic [1:0]  ctrl_ff;            // display and scan
  logic [3:0]  key_data_ff;        // captured returns
  logic [3:0]  key_return_in;      // synced port d

  // ==========================================================
  // axi write and read channel state
  logic        aw_held_ff;  // address taken
  logic        w_held_ff;   // data taken
  logic [6:0]  wr_idx_ff;   // register index
  logic [31:0] wdata_ff;    // held data
  logic [3:0]  wstrb_ff;    // held strobes
  logic        bvalid_ff;   // response pending
  logic [1:0]  bresp_ff;    // response code
  logic        rvalid_ff;   // read data pending
  logic [31:0] rdata_ff;    // read data
  logic [1:0]  rresp_ff;    // read response

  // handshakes; one write and one read at a time
  wire aw_fire  = s_awvalid && s_awready;
  wire w_fire   = s_wvalid && s_wready;
  wire ar_fire  = s_arvalid && s_arready;
  wire do_write = aw_held_ff && w_held_ff && !bvalid_ff;

  assign s_awready = !aw_held_ff && !bvalid_ff;
  assign s_wready  = !w_held_ff && !bvalid_ff;
  assign s_arready = !rvalid_ff;
  assign s_bvalid  = bvalid_ff;
  assign s_bresp   = bresp_ff;
  assign s_rvalid  = rvalid_ff;
  assign s_rdata   = rdata_ff;
  assign s_rresp   = rresp_ff;

  // ==========================================================
  // write decode
  wire lane0 = wstrb_ff[0]; // low byte
  wire lane1 = wstrb_ff[1]; // second byte
  wire wr_x_grp = do_write && wr_idx_ff == seg_port_pkg::IDX_X_GROUP;
  wire wr_y_grp = do_write && wr_idx_ff == seg_port_pkg::IDX_Y_GROUP;
  wire wr_sel   = do_write && lane0 && wr_idx_ff == seg_port_pkg::IDX_SEL;
  wire wr_adc   = do_write && lane0 && wr_idx_ff == seg_port_pkg::IDX_ADC;
  wire wr_ctrl  = do_write && lane0 && wr_idx_ff == seg_port_pkg::IDX_CTRL;
  wire wr_x_lo  = do_write && lane0 && wr_idx_ff == seg_port_pkg::IDX_X_LO;
  wire wr_x_hi  = do_write && lane0 && wr_idx_ff == seg_port_pkg::IDX_X_HI;
  wire wr_e     = do_write && lane0 && wr_idx_ff == seg_port_pkg::IDX_E;
  wire wr_f     = do_write && lane0 && wr_idx_ff == seg_port_pkg::IDX_F;

  // mapped indices, anything else answers slave error
  wire wr_hit = wr_x_grp || wr_y_grp ||
                wr_idx_ff == seg_port_pkg::IDX_SEL ||
                wr_idx_ff == seg_port_pkg::IDX_ADC ||
                wr_idx_ff == seg_port_pkg::IDX_CTRL ||
                wr_idx_ff == seg_port_pkg::IDX_X_LO ||
                wr_idx_ff == seg_port_pkg::IDX_X_HI ||
                wr_idx_ff == seg_port_pkg::IDX_E ||
                wr_idx_ff == seg_port_pkg::IDX_F ||
                wr_idx_ff == seg_port_pkg::IDX_KEY ||
                wr_idx_ff == seg_port_pkg::IDX_D_IN;

  // ==========================================================
  // address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      wr_idx_ff  <= 7'h00;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
    end else begin
      if (aw_fire) begin
        aw_held_ff <= 1'b1;
        wr_idx_ff  <= s_awaddr[8:2];
      end else if (do_write) begin
        aw_held_ff <= 1'b0;
      end
      if (w_fire) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= s_wdata;
        wstrb_ff  <= s_wstrb;
      end else if (do_write) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  // write response, raised at the edge that updates the latches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= seg_port_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_hit ? seg_port_pkg::RESP_OKAY : seg_port_pkg::RESP_SLVERR;
    end else if (s_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // ==========================================================
  // shared port and dot nibbles
  // next values; group loads take the low data buffer bits
  wire [3:0]  nxt_x_lo = wr_x_grp && lane0 ? wdata_ff[3:0] :
                         wr_x_lo ? wdata_ff[3:0] : seg_group_x_lo_ff;
  wire [3:0]  nxt_x_hi = wr_x_grp && lane0 ? {2'h0, wdata_ff[5:4]} :
                         wr_x_hi ? wdata_ff[3:0] : seg_group_x_hi_ff;
  wire [7:0]  nxt_y_lo = wr_y_grp && lane0 ? wdata_ff[7:0] : port_y_ff[7:0];
  wire [7:0]  nxt_y_hi = wr_y_grp && lane1 ? wdata_ff[15:8] : port_y_ff[15:8];
  wire [3:0]  nxt_e    = wr_e ? wdata_ff[3:0] : seg_group_e_out_ff;
  wire [3:0]  nxt_f    = wr_f ? wdata_ff[3:0] : seg_group_f_out_ff;

  // data latches survive clock stop and ce reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seg_group_x_lo_ff  <= seg_port_pkg::NIB_RST;
      seg_group_x_hi_ff  <= seg_port_pkg::NIB_RST;
      seg_group_e_out_ff <= seg_port_pkg::NIB_RST;
      seg_group_f_out_ff <= seg_port_pkg::NIB_RST;
      port_y_ff          <= seg_port_pkg::Y_RST;
    end else begin
      seg_group_x_lo_ff  <= nxt_x_lo;
      seg_group_x_hi_ff  <= nxt_x_hi;
      seg_group_e_out_ff <= nxt_e;
      seg_group_f_out_ff <= nxt_f;
      port_y_ff          <= {nxt_y_hi, nxt_y_lo};
    end
  end

  // ==========================================================
  // role and mode registers
  // clock stop acts like power-on; ce reset leaves roles alone
  wire stop_or_por = !aresetn || clock_stop;
  wire [3:0] nxt_sel  = wr_sel  ? wdata_ff[3:0] : sel_ff;
  wire [3:0] nxt_adc  = wr_adc  ? wdata_ff[3:0] : adc_ff;
  wire [1:0] nxt_ctrl = wr_ctrl ? wdata_ff[1:0] : ctrl_ff;

  always_ff @(posedge aclk) begin
    if (stop_or_por) begin
      sel_ff  <= seg_port_pkg::SEL_RST;
      adc_ff  <= seg_port_pkg::ADC_RST;
      ctrl_ff <= seg_port_pkg::CTRL_RST;
    end else begin
      sel_ff  <= nxt_sel;
      adc_ff  <= nxt_adc;
      ctrl_ff <= nxt_ctrl;
    end
  end

  wire disp_on  = ctrl_ff[seg_port_pkg::CTRL_DISP_BIT]; // display on
  wire scan_on  = ctrl_ff[seg_port_pkg::CTRL_SCAN_BIT] &&
                  !sel_ff[seg_port_pkg::SEL_Y_BIT];      // key scan live

  // ==========================================================
  // key scan timing
  // 13-bit counter, slots must stay at or below 8192 cycles
  seg_port_pkg::scan_phase_t phase_ff;  // current slot
  seg_port_pkg::scan_phase_t nxt_phase; // next slot
  logic [12:0] cnt_ff;  // cycles in slot
  logic [12:0] nxt_cnt; // next count

  wire [12:0] key_last = 13'(KEY_CYCLES - 1); // end of key slot
  wire [12:0] seg_last = 13'(SEG_CYCLES - 1); // end of seg slot
  wire key_phase = scan_on && phase_ff == seg_port_pkg::PH_KEY;
  wire key_end   = key_phase && cnt_ff == key_last;

  // slot sequencer; ce reset restarts it in the segment slot
  always_comb begin
    nxt_phase = phase_ff;
    nxt_cnt   = cnt_ff + 13'h0001;
    case (phase_ff)
      seg_port_pkg::PH_SEG: begin
        if (cnt_ff == seg_last) begin
          nxt_phase = seg_port_pkg::PH_KEY;
          nxt_cnt   = 13'h0000;
        end
      end
      seg_port_pkg::PH_KEY: begin
        if (cnt_ff == key_last) begin
          nxt_phase = seg_port_pkg::PH_SEG;
          nxt_cnt   = 13'h0000;
        end
      end
      default: begin
        nxt_phase = seg_port_pkg::PH_SEG;
        nxt_cnt   = 13'h0000;
      end
    endcase
    if (!scan_on || ce_reset) begin
      nxt_phase = seg_port_pkg::PH_SEG;
      nxt_cnt   = 13'h0000;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_ff <= seg_port_pkg::PH_SEG;
      cnt_ff   <= 13'h0000;
    end else begin
      phase_ff <= nxt_phase;
      cnt_ff   <= nxt_cnt;
    end
  end

  // ==========================================================
  // port d: synchroniser, converter select, pull-downs
  bit_sync #(
    .W (4)
  ) u_d_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (port_d_pin),
    .sync_ff (key_return_in)
  );

  // pin i is converter channel 2 + i
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pd
      wire adc_pin = adc_ff == seg_port_pkg::ADC_CH_D0 + 4'(gi);
      assign port_d_adc_sel[gi]  = adc_pin;
      // scan gates the pull-down to the key slot
      assign port_d_pulldown[gi] = !adc_pin &&
                                   (!scan_on || key_phase);
    end
  endgenerate

  // returns sampled on the last cycle of the key slot
  always_ff @(posedge aclk) begin
    if (!aresetn) key_data_ff <= seg_port_pkg::NIB_RST;
    else if (key_end) key_data_ff <= key_return_in;
  end

  // ==========================================================
  // pin groups; only group y carries key source
  seg_pin_group #(.W (4)) u_grp_f (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .gp_mode   (sel_ff[seg_port_pkg::SEL_F_BIT]),
    .disp_on   (disp_on),
    .key_phase (1'b0),
    .seg_drv   (lcd_seg_f),
    .port_dat  (seg_group_f_out_ff),
    .key_dat   (4'h0),
    .pin_ff    (seg_pin_f)
  );
  seg_pin_group #(.W (4)) u_grp_e (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .gp_mode   (sel_ff[seg_port_pkg::SEL_E_BIT]),
    .disp_on   (disp_on),
    .key_phase (1'b0),
    .seg_drv   (lcd_seg_e),
    .port_dat  (seg_group_e_out_ff),
    .key_dat   (4'h0),
    .pin_ff    (seg_pin_e)
  );
  seg_pin_group #(.W (6)) u_grp_x (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .gp_mode   (sel_ff[seg_port_pkg::SEL_X_BIT]),
    .disp_on   (disp_on),
    .key_phase (1'b0),
    .seg_drv   (lcd_seg_x),
    .port_dat  ({seg_group_x_hi_ff[1:0], seg_group_x_lo_ff}),
    .key_dat   (6'h00),
    .pin_ff    (seg_pin_x)
  );
  seg_pin_group #(.W (16)) u_grp_y (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .gp_mode   (sel_ff[seg_port_pkg::SEL_Y_BIT]),
    .disp_on   (disp_on),
    .key_phase (key_phase),
    .seg_drv   (lcd_seg_y),
    .port_dat  (port_y_ff),
    .key_dat   (port_y_ff),
    .pin_ff    (seg_pin_y)
  );

  assign key_scan_drive = key_phase;
  assign dot_nibble_13  = seg_group_f_out_ff;
  assign dot_nibble_11  = seg_group_e_out_ff;
  assign dot_nibble_9   = seg_group_x_hi_ff;
  assign dot_nibble_8   = seg_group_x_lo_ff;

  // ==========================================================
  // read path
  wire [6:0]  rd_idx = s_araddr[8:2]; // register index
  wire [31:0] rd_val =
    rd_idx == seg_port_pkg::IDX_X_GROUP ?
      {26'h0, seg_group_x_hi_ff[1:0], seg_group_x_lo_ff} :
    rd_idx == seg_port_pkg::IDX_Y_GROUP ? {16'h0000, port_y_ff} :
    rd_idx == seg_port_pkg::IDX_SEL  ? {28'h0, sel_ff} :
    rd_idx == seg_port_pkg::IDX_ADC  ? {28'h0, adc_ff} :
    rd_idx == seg_port_pkg::IDX_CTRL ? {30'h0, ctrl_ff} :
    rd_idx == seg_port_pkg::IDX_KEY  ? {28'h0, key_data_ff} :
    rd_idx == seg_port_pkg::IDX_X_LO ? {28'h0, seg_group_x_lo_ff} :
    rd_idx == seg_port_pkg::IDX_X_HI ? {28'h0, seg_group_x_hi_ff} :
    rd_idx == seg_port_pkg::IDX_E    ? {28'h0, seg_group_e_out_ff} :
    rd_idx == seg_port_pkg::IDX_F    ? {28'h0, seg_group_f_out_ff} :
    {28'h0, key_return_in};
  wire rd_hit = rd_idx == seg_port_pkg::IDX_X_GROUP ||
                rd_idx == seg_port_pkg::IDX_Y_GROUP ||
                rd_idx == seg_port_pkg::IDX_SEL ||
                rd_idx == seg_port_pkg::IDX_ADC ||
                rd_idx == seg_port_pkg::IDX_CTRL ||
                rd_idx == seg_port_pkg::IDX_KEY ||
                rd_idx == seg_port_pkg::IDX_X_LO ||
                rd_idx == seg_port_pkg::IDX_X_HI ||
                rd_idx == seg_port_pkg::IDX_E ||
                rd_idx == seg_port_pkg::IDX_F ||
                rd_idx == seg_port_pkg::IDX_D_IN;

  // reads have no side effect anywhere
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= seg_port_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_hit ? rd_val : 32'h0000_0000;
      rresp_ff  <= rd_hit ? seg_port_pkg::RESP_OKAY : seg_port_pkg::RESP_SLVERR;
    end else if (s_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
endmodule : segment_pin_port_mux
`default_nettype wire

// ===== segment_pin_port_mux_props.sv
// port-level assertions for the segment pin port mux
`timescale 1ns/1ns
`default_nettype none
module segment_pin_port_mux_props (
  input wire logic        aclk, aresetn, clock_stop, ce_reset,              // clock, resets
  input wire logic        s_arvalid, s_arready, s_rvalid, s_rready, s_bvalid, s_bready, // handshakes
  input wire logic [1:0]  s_bresp,                                          // write response
  input wire logic [31:0] s_rdata,                                          // read data
  input wire logic [3:0]  dot_nibble_13, dot_nibble_11, dot_nibble_9, dot_nibble_8, // dot data
  input wire logic [3:0]  seg_pin_f, seg_pin_e, port_d_pulldown, port_d_adc_sel,   // pins
  input wire logic [5:0]  seg_pin_x,                                        // group x pins
  input wire logic [15:0] seg_pin_y,                                        // group y pins
  input wire logic        key_scan_drive                                    // key slot
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // reset, stop and ce reset
  reset_state_a: assert property (disable iff (1'b0) !aresetn |=> port_d_pulldown == 4'hf
    && {seg_pin_f, seg_pin_e, seg_pin_x, seg_pin_y} == 30'h0 && !s_bvalid && !s_rvalid) else $error("reset state");
  stop_low_a: assert property (clock_stop |-> ##2 {seg_pin_f, seg_pin_e, seg_pin_x, seg_pin_y} == 30'h0)
    else $error("pins not low after stop");
  stop_clear_a: assert property (clock_stop |=> port_d_adc_sel == 4'h0 && !key_scan_drive)
    else $error("stop kept roles");
  ce_keeps_a: assert property (ce_reset |=> $stable(port_d_adc_sel) && $stable(dot_nibble_13))
    else $error("ce reset changed state");
  // ==========================================================
  // data nibbles move only with a write answer
  nib_by_write_a: assert property (!$stable({dot_nibble_13, dot_nibble_11, dot_nibble_9, dot_nibble_8})
    |-> $rose(s_bvalid)) else $error("dot nibble moved without write");
  read_lat_a: assert property (s_arvalid && s_arready |=> s_rvalid) else $error("read answer late");
  rd_hold_a: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata)) else $error("rdata dropped");
  wr_hold_a: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp)) else $error("bresp dropped");
  // ==========================================================
  // port d pull-downs against converter and key slot
  adc_pull_a: assert property ((port_d_adc_sel & port_d_pulldown) == 4'h0 && $onehot0(port_d_adc_sel))
    else $error("converter pin pull-down");
  key_pull_a: assert property (key_scan_drive |-> port_d_pulldown == ~port_d_adc_sel)
    else $error("pull-down off in key slot");
endmodule : segment_pin_port_mux_props
`default_nettype wire

// ===== key_matrix_model.sv
// key matrix on the port d return lines, one column on group y pin 0
`timescale 1ns/1ns
`default_nettype none
module key_matrix_model (
  input  wire logic       aclk,    // clock
  input  wire logic       src,     // key source column
  input  wire logic [3:0] keys,    // closed contacts
  input  wire logic [3:0] pull_dn, // pull-down enables
  output logic      [3:0] ret      // return lines
);
  logic [3:0] drift = 4'h5; // open lines wander, no level is promised
  always @(posedge aclk) drift <= ~drift;
  // closed contact shows the source, open line the pull-down or drift
  always_comb for (int i = 0; i < 4; i++) ret[i] = keys[i] ? src : (pull_dn[i] ? 1'b0 : drift[i]);
endmodule : key_matrix_model
`default_nettype wire

// ===== segment_pin_port_mux_test.sv
// self-checking bench for the segment pin port mux
`timescale 1ns/1ns
`default_nettype none
module segment_pin_port_mux_test;
  logic        aclk = 1'h0, aresetn = 1'h0, clock_stop = 1'h0, ce_reset = 1'h0;
  logic        s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0, s_arvalid = 1'h0, s_rready = 1'h0;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, key_scan_drive;
  logic [11:0] s_awaddr = 12'h0, s_araddr = 12'h0;
  logic [31:0] s_wdata = 32'h0, s_rdata;
  logic [1:0]  s_bresp, s_rresp;
  logic [3:0]  s_wstrb = 4'hf, lcd_seg_f = 4'hf, lcd_seg_e = 4'hf, keys = 4'h0;
  logic [3:0]  dot_nibble_13, dot_nibble_11, dot_nibble_9, dot_nibble_8, seg_pin_f, seg_pin_e;
  logic [3:0]  port_d_pin, port_d_pulldown, port_d_adc_sel;
  logic [5:0]  lcd_seg_x = 6'h3f, seg_pin_x;
  logic [15:0] lcd_seg_y = 16'h5a5a, seg_pin_y;
  int          err_count = 0, comparisons = 0;
  // short slots keep the key scan test brief
  segment_pin_port_mux #(.KEY_CYCLES(8), .SEG_CYCLES(10)) u_segment_pin_port_mux (.*);
  key_matrix_model u_key_matrix_model (.aclk, .src(seg_pin_y[0]), .keys, .pull_dn(port_d_pulldown), .ret(port_d_pin));
  always #25 aclk = ~aclk;
  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // one write (w=1) or read; handshakes sampled at the falling edge before the taking edge
  task automatic bus(input logic w, input logic [6:0] i, input logic [31:0] d, input logic [1:0] r);
    logic a, v, c, b = 1'b0;
    @(posedge aclk); // one edge between transfers, no double drive in a time step
    s_awaddr <= {3'h0, i, 2'h0};
    s_araddr <= {3'h0, i, 2'h0};
    s_wdata <= d;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} <= {w, w, w, !w, !w};
    while (!b) begin
      @(negedge aclk);
      {a, v, c, b} = {s_awready, s_wready, s_arready, w ? s_bvalid : s_rvalid};
      if (b) chk(32'(w ? s_bresp : s_rresp), 32'(r));
      if (b && !w) chk(s_rdata, d);
      @(posedge aclk);
      {s_awvalid, s_wvalid, s_arvalid} <= {s_awvalid & ~a, s_wvalid & ~v, s_arvalid & ~c};
    end
    {s_bready, s_rready} <= 2'h0;
  endtask : bus
  task automatic wkd(input logic v);
    repeat (40) if (key_scan_drive !== v) @(negedge aclk);
  endtask : wkd
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // ==========================================================
  // scenarios
  task automatic t_out;
    chk(32'({seg_pin_f, seg_pin_e, seg_pin_x, seg_pin_y}), 32'h0);
    bus(1, 7'h11, 32'hf, 2'h0);
    bus(1, 7'h6d, 32'ha, 2'h0);
    bus(1, 7'h6b, 32'h5, 2'h0);
    bus(1, 7'h69, 32'h3, 2'h0);
    bus(1, 7'h68, 32'hc, 2'h0);
    @(negedge aclk);
    chk(32'({dot_nibble_13, dot_nibble_11, seg_pin_f, seg_pin_e, seg_pin_x}), 32'h29697c);
    bus(1, 7'h0c, 32'h25, 2'h0);
    bus(1, 7'h42, 32'h1, 2'h0);
    @(negedge aclk);
    chk(32'({dot_nibble_9, dot_nibble_8, seg_pin_x, seg_pin_y}), 32'h09650001);
    bus(0, 7'h0c, 32'h25, 2'h0);
    $display("output test done");
  endtask : t_out
  task automatic t_in;
    keys <= 4'h9;
    repeat (4) @(posedge aclk);
    bus(0, 7'h72, 32'h9, 2'h0);
    bus(1, 7'h72, 32'h0, 2'h0);
    bus(0, 7'h72, 32'h9, 2'h0);
    bus(1, 7'h01, 32'h1, 2'h2);
    bus(0, 7'h01, 32'h0, 2'h2);
    for (int i = 0; i < 4; i++) begin
      bus(1, 7'h14, 32'(i + 2), 2'h0);
      @(negedge aclk);
      chk(32'({port_d_adc_sel, port_d_pulldown}), 32'((16 << i) | (~(1 << i) & 15)));
    end
    bus(1, 7'h14, 32'h0, 2'h0);
    $display("input test done");
  endtask : t_in
  task automatic t_scan;
    bus(1, 7'h11, 32'h7, 2'h0);
    bus(1, 7'h15, 32'h3, 2'h0);
    wkd(1'h1);
    chk(32'(port_d_pulldown), 32'hf);
    wkd(1'h0);
    chk(32'(port_d_pulldown), 32'h0);
    @(negedge aclk);
    chk(32'(seg_pin_y), 32'h5a5a);
    bus(0, 7'h17, 32'h9, 2'h0);
    ce_reset <= 1'h1;
    @(posedge aclk);
    ce_reset <= 1'h0;
    bus(0, 7'h11, 32'h7, 2'h0);
    clock_stop <= 1'h1;
    @(posedge aclk);
    clock_stop <= 1'h0;
    repeat (2) @(negedge aclk);
    chk(32'({seg_pin_f, seg_pin_y, dot_nibble_13}), 32'ha);
    bus(0, 7'h15, 32'h0, 2'h0);
    $display("scan and reset test done");
  endtask : t_scan
  // ==========================================================
  // main sequence and watchdog, the run needs well under 2000 cycles
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_out;
    t_in;
    t_scan;
    end_sim;
  end
  initial begin
    #200000;
    err_count++;
    end_sim;
  end
endmodule : segment_pin_port_mux_test
bind segment_pin_port_mux segment_pin_port_mux_props u_segment_pin_port_mux_props (.*);
`default_nettype wire
